// >>> ssq_supply_reset_seq.sv
// Notes on behaviour
// - five reset levels: power-on down to processor
// - power-on rising releases, starts reference and monitor
// - lowest threshold rising continues boot, starts pmu
// - below lowest threshold holds brownout reset
// - higher threshold fall: interrupt, drop to lowest
// - threshold selection has four levels, zero lowest
// - startup always forces lowest threshold
// - rtc reset by boot, brownout, power-on only
`timescale 1ns/1ps
module ssq_supply_reset_seq (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic por_above_in,
  input wire logic bor_above_in,
  input wire logic thr_wr_in,
  input wire ssq_pkg::ssq_thr_t thr_wr_val_in,
  input wire ssq_pkg::ssq_sw_req_t sw_req_in,
  output logic ref_enable_out,
  output logic bor_enable_out,
  output logic pmu_enable_out,
  output ssq_pkg::ssq_thr_t bor_thr_sel_out,
  output logic bor_irq_out,
  output ssq_pkg::ssq_levels_t resets_out,
  output logic rtc_reset_out
);

  // =====================================================================
  // state and registers
  // =====================================================================
  ssq_pkg::ssq_state_t state_q;
  ssq_pkg::ssq_state_t state_d;
  ssq_pkg::ssq_thr_t thr_q;
  ssq_pkg::ssq_thr_t thr_d;
  ssq_pkg::ssq_levels_t lvl_q;
  ssq_pkg::ssq_levels_t lvl_d;
  logic irq_q;
  logic ref_en_q;
  logic pmu_en_q;
  logic stage_done;

  // =====================================================================
  // decode of monitor inputs
  // =====================================================================
  wire in_run = (state_q == ssq_pkg::SSQ_S_RUN);
  wire at_lowest = (thr_q == ssq_pkg::SSQ_THR_LOWEST);
  // a fall seen while a higher level is selected is only a warning; not gated by run,
  // since a raised level can outlive run for one cycle and that fall must not be lost
  wire warn_fall = !at_lowest && !bor_above_in;
  // a fall at the lowest level is a real brownout
  wire lowest_brownout_threshold_fall = at_lowest && !bor_above_in;
  wire past_ref = (state_q != ssq_pkg::SSQ_S_POR) && (state_q != ssq_pkg::SSQ_S_REF)
                  && (state_q != ssq_pkg::SSQ_S_BOR);
  wire stage_start = (state_d != state_q);

  // =====================================================================
  // stage spacing between level releases
  // =====================================================================
  ssq_settle_timer u_timer (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .start_in(stage_start),
    .done_out(stage_done)
  );

  // =====================================================================
  // next state
  // =====================================================================
  // power-on loss wins over everything, then brownout, then software
  always_comb begin
    state_d = state_q;
    if (!por_above_in) begin
      state_d = ssq_pkg::SSQ_S_POR;
    end else begin
      unique case (state_q)
        ssq_pkg::SSQ_S_POR: state_d = ssq_pkg::SSQ_S_REF;
        ssq_pkg::SSQ_S_REF, ssq_pkg::SSQ_S_BOR: begin
          if (at_lowest && bor_above_in) state_d = ssq_pkg::SSQ_S_PMU;
        end
        ssq_pkg::SSQ_S_PMU: begin
          if (lowest_brownout_threshold_fall) state_d = ssq_pkg::SSQ_S_BOR;
          else if (stage_done) state_d = ssq_pkg::SSQ_S_BOOT;
        end
        ssq_pkg::SSQ_S_BOOT: begin
          if (lowest_brownout_threshold_fall) state_d = ssq_pkg::SSQ_S_BOR;
          else if (sw_req_in.boot) state_d = ssq_pkg::SSQ_S_PMU;
          else if (stage_done) state_d = ssq_pkg::SSQ_S_SYS;
        end
        ssq_pkg::SSQ_S_SYS: begin
          if (lowest_brownout_threshold_fall) state_d = ssq_pkg::SSQ_S_BOR;
          else if (sw_req_in.boot) state_d = ssq_pkg::SSQ_S_PMU;
          else if (sw_req_in.sys) state_d = ssq_pkg::SSQ_S_BOOT;
          else if (stage_done) state_d = ssq_pkg::SSQ_S_RUN;
        end
        ssq_pkg::SSQ_S_RUN: begin
          if (lowest_brownout_threshold_fall) state_d = ssq_pkg::SSQ_S_BOR;
          else if (sw_req_in.boot) state_d = ssq_pkg::SSQ_S_PMU;
          else if (sw_req_in.sys) state_d = ssq_pkg::SSQ_S_BOOT;
          else if (sw_req_in.cpu) state_d = ssq_pkg::SSQ_S_SYS;
        end
        default: state_d = ssq_pkg::SSQ_S_POR;
      endcase
    end
  end

  // =====================================================================
  // reset levels, nested from the state about to be entered
  // =====================================================================
  assign lvl_d.por = (state_d == ssq_pkg::SSQ_S_POR);
  assign lvl_d.bor = lvl_d.por || (state_d == ssq_pkg::SSQ_S_REF)
                     || (state_d == ssq_pkg::SSQ_S_BOR);
  assign lvl_d.boot = lvl_d.bor || (state_d == ssq_pkg::SSQ_S_PMU);
  assign lvl_d.sys = lvl_d.boot || (state_d == ssq_pkg::SSQ_S_BOOT);
  assign lvl_d.cpu = lvl_d.sys || (state_d == ssq_pkg::SSQ_S_SYS);

  // =====================================================================
  // threshold selection
  // =====================================================================
  // outside run the selection is pinned low; a warning fall beats a write
  // in the same cycle so the drop to the lowest level is never lost
  assign thr_d = !in_run ? ssq_pkg::SSQ_THR_LOWEST :
                 warn_fall ? ssq_pkg::SSQ_THR_LOWEST :
                 thr_wr_in ? thr_wr_val_in : thr_q;

  // =====================================================================
  // registers
  // =====================================================================
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q <= ssq_pkg::SSQ_S_POR;
      thr_q <= ssq_pkg::THR_RESET;
      lvl_q <= ssq_pkg::LEVELS_ALL;
      irq_q <= 1'b0;
      ref_en_q <= 1'b0;
      pmu_en_q <= 1'b0;
    end else begin
      state_q <= state_d;
      thr_q <= thr_d;
      lvl_q <= lvl_d;
      irq_q <= warn_fall;
      ref_en_q <= (state_d != ssq_pkg::SSQ_S_POR);
      pmu_en_q <= !lvl_d.bor;
    end
  end

  // reference and monitor share one enable; the monitor needs the reference
  assign ref_enable_out = ref_en_q;
  assign bor_enable_out = ref_en_q;
  assign pmu_enable_out = pmu_en_q;
  assign bor_thr_sel_out = thr_q;
  assign bor_irq_out = irq_q;
  assign resets_out = lvl_q;
  // the rtc survives system and processor resets
  assign rtc_reset_out = lvl_q.boot;

  // =====================================================================
  // assertions
  // =====================================================================
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  nest_chain_a: assert property (
    (!resets_out.por || resets_out.bor) && (!resets_out.bor || resets_out.boot)
    && (!resets_out.boot || resets_out.sys) && (!resets_out.sys || resets_out.cpu))
    else $error("reset levels not nested");

  por_hold_a: assert property (!por_above_in |=> resets_out.por
    && !ref_enable_out && !pmu_enable_out)
    else $error("power-on loss did not hold power-on reset");

  ref_start_a: assert property (
    (state_q == ssq_pkg::SSQ_S_POR) && por_above_in
    |=> !resets_out.por && ref_enable_out && bor_enable_out && resets_out.bor)
    else $error("power-on release did not start reference");

  pmu_start_a: assert property (
    (state_q == ssq_pkg::SSQ_S_REF) && por_above_in && bor_above_in
    |=> pmu_enable_out && !resets_out.bor && resets_out.boot)
    else $error("lowest threshold rise did not start pmu");

  bor_hold_a: assert property (
    por_above_in && past_ref && lowest_brownout_threshold_fall
    |=> (resets_out.bor && !resets_out.por) ##1 (resets_out.bor || $past(bor_above_in)))
    else $error("lowest threshold fall did not hold brownout reset");

  warn_drop_a: assert property (
    por_above_in && warn_fall
    |=> bor_irq_out && (bor_thr_sel_out == ssq_pkg::SSQ_THR_LOWEST)
    ##1 !bor_irq_out || !bor_above_in)
    else $error("warning fall did not raise irq and drop threshold");

  startup_low_a: assert property (
    (state_q != ssq_pkg::SSQ_S_RUN) |=> (bor_thr_sel_out == ssq_pkg::SSQ_THR_LOWEST))
    else $error("threshold not lowest during startup");

  sw_thr_a: assert property (
    in_run && thr_wr_in && bor_above_in && por_above_in
    |=> bor_thr_sel_out == $past(thr_wr_val_in))
    else $error("software threshold write not applied");

  rtc_keep_a: assert property (
    in_run && por_above_in && bor_above_in && !sw_req_in.boot && sw_req_in.sys
    |=> (resets_out.sys && !rtc_reset_out)
    ##1 (!rtc_reset_out || !$past(bor_above_in) || !$past(por_above_in)
    || $past(sw_req_in.boot)))
    else $error("system reset disturbed rtc");

  run_reach_c: cover property ((state_q == ssq_pkg::SSQ_S_SYS) ##1 in_run);
  warn_irq_c: cover property (bor_irq_out);
  bor_hold_c: cover property (state_q == ssq_pkg::SSQ_S_BOR);
  cpu_reset_c: cover property (in_run && sw_req_in.cpu ##1 resets_out.cpu && !resets_out.sys);

endmodule // ssq_supply_reset_seq

// >>> ssq_pkg.sv
package ssq_pkg;

  // =====================================================================
  // timing
  // =====================================================================
  // clock period and spacing between the release of two reset levels
  localparam int CLK_PERIOD_NS = 8;
  localparam int STAGE_TIME_NS = 64;
  // a least time, so round up; never below one cycle
  localparam int STAGE_CYC_RAW = (STAGE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STAGE_CYCLES = (STAGE_CYC_RAW < 1) ? 1 : STAGE_CYC_RAW;
  localparam int STAGE_CNT_W = 4;
  localparam logic [STAGE_CNT_W-1:0] STAGE_LAST = STAGE_CNT_W'(STAGE_CYCLES - 1);

  // =====================================================================
  // brownout threshold selection, level 0 is the lowest voltage
  // =====================================================================
  typedef enum logic [1:0] {
    SSQ_THR_LOWEST = 2'h0,
    SSQ_THR_LVL1 = 2'h1,
    SSQ_THR_LVL2 = 2'h2,
    SSQ_THR_LVL3 = 2'h3
  } ssq_thr_t;
  localparam ssq_thr_t THR_RESET = SSQ_THR_LOWEST;

  // =====================================================================
  // sequencer states, gray coded along power-up path
  // =====================================================================
  typedef enum logic [2:0] {
    SSQ_S_POR = 3'h0,   // power-on reset hold
    SSQ_S_REF = 3'h1,   // reference and brownout monitor started
    SSQ_S_PMU = 3'h3,   // power management unit started, boot reset held
    SSQ_S_BOOT = 3'h2,  // boot reset released, system reset held
    SSQ_S_SYS = 3'h6,   // system reset released, processor reset held
    SSQ_S_RUN = 3'h7,   // all resets released
    SSQ_S_BOR = 3'h5    // brownout reset hold
  } ssq_state_t;

  // =====================================================================
  // reset levels, strongest first
  // =====================================================================
  typedef struct packed {
    logic por;
    logic bor;
    logic boot;
    logic sys;
    logic cpu;
  } ssq_levels_t;
  localparam ssq_levels_t LEVELS_ALL = 5'h1f;

  // software reset requests, one-cycle pulses
  typedef struct packed {
    logic boot;
    logic sys;
    logic cpu;
  } ssq_sw_req_t;

endpackage

// >>> ssq_settle_timer.sv
`timescale 1ns/1ps
module ssq_settle_timer (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic start_in,
  output logic done_out
);

  // =====================================================================
  // stage timer
  // =====================================================================
  logic [ssq_pkg::STAGE_CNT_W-1:0] count_q;
  logic [ssq_pkg::STAGE_CNT_W-1:0] count_d;
  logic done_q;
  wire at_last = (count_q == ssq_pkg::STAGE_LAST);

  // restart on every state change, saturate at the last count
  assign count_d = start_in ? '0 : (at_last ? count_q : count_q + 1'b1);

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      count_q <= '0;
      done_q <= 1'b0;
    end else begin
      count_q <= count_d;
      done_q <= !start_in && (count_d == ssq_pkg::STAGE_LAST);
    end
  end

  assign done_out = done_q;

endmodule // ssq_settle_timer

// >>> ssq_supply_model.sv
`timescale 1ns/1ps
// =====================================================================
// supply detectors: power-on comparator and brownout monitor
// =====================================================================
module ssq_supply_model #(
  parameter logic [7:0] POR_LVL = 8'h20
) (
  input wire logic [7:0] vdd_in,
  input wire logic mon_en_in,
  input wire ssq_pkg::ssq_thr_t thr_sel_in,
  output logic por_above_out,
  output logic bor_above_out
);
  logic [7:0] thr_lvl;
  // four trip points, code 0 the lowest voltage
  assign thr_lvl = 8'h40 + {2'h0, thr_sel_in, 4'h0};
  // comparators follow the supply at once, so a threshold change is seen next edge
  assign por_above_out = (vdd_in >= POR_LVL);
  // a disabled monitor reports low rather than a stale level
  assign bor_above_out = mon_en_in && (vdd_in >= thr_lvl);
endmodule // ssq_supply_model

// >>> tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic clk_in, rst_in, thr_wr_in, por_a, bor_a, ref_en, bor_en, pmu_en, irq, rtc;
  logic [7:0] vdd;
  ssq_pkg::ssq_thr_t thr_wr_val_in, thr;
  ssq_pkg::ssq_sw_req_t sw_req_in;
  ssq_pkg::ssq_levels_t resets, last_res;
  ssq_pkg::ssq_levels_t res_q[$];
  ssq_pkg::ssq_thr_t irq_q[$];
  int n_fail, cmp_count;
  int cyc = 0;

  ssq_supply_model i_ssq_supply_model (.vdd_in(vdd), .mon_en_in(bor_en), .thr_sel_in(thr),
    .por_above_out(por_a), .bor_above_out(bor_a));
  ssq_supply_reset_seq i_ssq_supply_reset_seq (.clk_in(clk_in), .rst_in(rst_in),
    .por_above_in(por_a), .bor_above_in(bor_a), .thr_wr_in(thr_wr_in),
    .thr_wr_val_in(thr_wr_val_in), .sw_req_in(sw_req_in), .ref_enable_out(ref_en),
    .bor_enable_out(bor_en), .pmu_enable_out(pmu_en), .bor_thr_sel_out(thr),
    .bor_irq_out(irq), .resets_out(resets), .rtc_reset_out(rtc));

  // =====================================================================
  // compare and closing tasks
  // =====================================================================
  task automatic cmp_res(input ssq_pkg::ssq_levels_t got, input ssq_pkg::ssq_levels_t exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_val(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("compares %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // =====================================================================
  // stimulus helpers
  // =====================================================================
  // each release step drops the strongest level still held
  task automatic push_up(input int from);
    for (int i = from; i < 6; i++) res_q.push_back(5'h1f >> i);
  endtask
  // bounded wait for all noted reset changes to appear
  task automatic drain();
    for (int i = 0; i < 300 && res_q.size() > 0; i++) @(posedge clk_in);
    repeat (3) @(posedge clk_in);
    cmp_val(8'(res_q.size()), 8'h0);
  endtask
  task automatic wr_thr(input ssq_pkg::ssq_thr_t l);
    @(posedge clk_in);
    thr_wr_in <= 1'b1;
    thr_wr_val_in <= l;
    @(posedge clk_in);
    thr_wr_in <= 1'b0;
    repeat (2) @(posedge clk_in);
  endtask
  task automatic sw(input ssq_pkg::ssq_sw_req_t r);
    @(posedge clk_in);
    sw_req_in <= r;
    @(posedge clk_in);
    sw_req_in <= '0;
  endtask

  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end

  // watcher: every reset change takes the oldest note; enables and rtc follow levels
  always @(posedge clk_in) begin
    #1;
    if (resets !== last_res) begin
      cmp_res(resets, (res_q.size() > 0) ? res_q.pop_front() : last_res);
      cmp_val({4'h0, rtc, ref_en, bor_en, pmu_en},
        {4'h0, resets.boot, ~resets.por, ~resets.por, ~resets.bor});
      last_res = resets;
    end
    if (irq === 1'b1) begin
      cmp_val(8'(irq_q.size()), 8'h1);
      if (irq_q.size() > 0) cmp_val(8'(thr), 8'(irq_q.pop_front()));
    end
  end

  // hang guard, far above the few hundred cycles the run needs
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      close_out();
    end
  end

  initial begin
    void'($urandom(32'h7ec8));
    rst_in = 1'b1;
    vdd = 8'h90;
    thr_wr_in = 1'b0;
    thr_wr_val_in = ssq_pkg::SSQ_THR_LOWEST;
    sw_req_in = '0;
    n_fail = 0;
    cmp_count = 0;
    last_res = 5'h1f;
    repeat (3) @(posedge clk_in);
    #1 cmp_res(resets, 5'h1f);
    cmp_val(8'(thr), 8'h0);
    @(posedge clk_in) rst_in <= 1'b0;
    push_up(1);
    drain();
    // each higher level: accepted, then a fall warns and drops to lowest
    for (int l = 1; l < 4; l++) begin
      @(posedge clk_in) vdd <= 8'h71 + 8'($urandom % 143);
      wr_thr(ssq_pkg::ssq_thr_t'(l));
      #1 cmp_val(8'(thr), 8'(l));
      irq_q.push_back(ssq_pkg::SSQ_THR_LOWEST);
      @(posedge clk_in) vdd <= 8'h40 + 8'($urandom % 16);
      repeat (4) @(posedge clk_in);
      #1 cmp_val(8'(thr), 8'h0);
      @(posedge clk_in) vdd <= 8'h90;
    end
    // brownout below the lowest trip point, then recovery
    res_q.push_back(5'h0f);
    @(posedge clk_in) vdd <= 8'h30;
    drain();
    push_up(2);
    @(posedge clk_in) vdd <= 8'h90;
    drain();
    // software processor, system, boot requests; rtc only on boot
    for (int k = 0; k < 3; k++) begin
      push_up(4 - k);
      sw(ssq_pkg::ssq_sw_req_t'(3'h1 << k));
      drain();
    end
    // restart after a raised threshold must come up at the lowest
    wr_thr(ssq_pkg::SSQ_THR_LVL2);
    #1 cmp_val(8'(thr), 8'h2);
    res_q.push_back(5'h1f);
    @(posedge clk_in) rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    #1 cmp_val(8'(thr), 8'h0);
    push_up(1);
    @(posedge clk_in) rst_in <= 1'b0;
    drain();
    // supply collapse below the power-on level, then power back
    res_q.push_back(5'h1f);
    @(posedge clk_in) vdd <= 8'h10;
    drain();
    push_up(1);
    @(posedge clk_in) vdd <= 8'h90;
    drain();
    cmp_val(8'(irq_q.size()), 8'h0);
    close_out();
  end
endmodule // tb_top
